// *** tdr_pkg.sv ***
// Shared constants and types for the table-driven receive engine
package tdr_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] REG_SCR = 8'h00;
  localparam logic [7:0] REG_RICR = 8'h04;
  localparam logic [7:0] REG_CBSR = 8'h08;
  localparam logic [7:0] REG_TBASE = 8'h0C;
  localparam logic [7:0] REG_LSEL = 8'h10;
  localparam logic [7:0] REG_LADDR = 8'h14;
  localparam logic [7:0] REG_LCOUNT = 8'h18;
  localparam logic [7:0] REG_LPROTO = 8'h1C;
  localparam logic [7:0] REG_LSTATE = 8'h20;
  localparam logic [7:0] REG_LBCC = 8'h24;
  localparam int REG_AW = 8;
  // System control fields
  localparam int SCR_IRQ_EN = 6;
  localparam int SCR_IRQ_FLAG = 7;
  localparam int SCR_RESUME = 8;
  // Line protocol word fields
  localparam int PROTO_COUNT_RX = 5;
  localparam int PROTO_POLY_LO = 0;
  // Line state word: low bits hold the receive mode, high byte the pseudo control byte
  localparam int STATE_PSEUDO_LO = 8;
  localparam int COUNT_MODE_BIT = 15;
  // Block check polynomial selects
  localparam logic [1:0] POLY_LRC = 2'h0;
  localparam logic [1:0] POLY_CRC16 = 2'h1;
  localparam logic [1:0] POLY_CCITT = 2'h2;
  localparam logic [15:0] CRC16_REFL = 16'hA001;
  localparam logic [15:0] CCITT_REFL = 16'h8408;
  // Interrupt character codes and the number of block check characters
  localparam logic [3:0] CODE_SPECIAL = 4'h8;
  localparam logic [3:0] CODE_EXHAUST = 4'h9;
  localparam logic [1:0] BCC_CHARS = 2'h2;
  // Async frame bit positions and the last bit of a sync character
  localparam logic [3:0] ABIT_LAST_DATA = 4'h8;
  localparam logic [3:0] ABIT_PARITY = 4'h9;
  localparam logic [3:0] SBIT_LAST = 4'h7;

  // One received character as it travels through the FIFO
  typedef struct packed {
    logic [2:0] err;  // [2] framing, [1] overrun, [0] parity
    logic [3:0] line;
    logic [7:0] ch;
  } tdr_entry_t;

  // Control byte, also used for the pseudo control byte
  typedef struct packed {
    logic [1:0] rsvd;
    logic store;
    logic bcc;
    logic irq;
    logic [2:0] mode;
  } tdr_cb_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_FETCH = 3'h1,
    SEQ_ACT = 3'h3,
    SEQ_STORE = 3'h2,
    SEQ_WAIT = 3'h6
  } tdr_seq_t;
endpackage : tdr_pkg

// *** tdr_rx_engine.sv ***
// Receive engine: line receivers, shared character FIFO, table-driven sequencer
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module tdr_rx_engine #(
  parameter int NUM_LINES = 16,
  parameter int SYNC_LINES = 8,
  parameter int FIFO_DEPTH = 128,
  parameter int ADDR_W = 32,
  parameter logic [7:0] SYNC_CHAR = 8'h96,
  parameter bit PAR_EN = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus slave
  input wire logic wbs_cyc_i,
  input wire logic wbs_stb_i,
  input wire logic wbs_we_i,
  input wire logic [31:0] wbs_adr_i,
  input wire logic [3:0] wbs_sel_i,
  input wire logic [31:0] wbs_dat_i,
  output logic [31:0] wbs_dat_o,
  output logic wbs_ack_o,
  // Memory bus master
  output logic wbm_cyc_o,
  output logic wbm_stb_o,
  output logic wbm_we_o,
  output logic [ADDR_W-1:0] wbm_adr_o,
  output logic [3:0] wbm_sel_o,
  output logic [31:0] wbm_dat_o,
  input wire logic [31:0] wbm_dat_i,
  input wire logic wbm_ack_i,
  // Serial lines, one bit strobe each at mid-bit
  input wire logic [NUM_LINES-1:0] rxData,
  input wire logic [NUM_LINES-1:0] rxBitStb,
  // Interrupt request
  output logic rxIrq
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int LW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;
  localparam int REG_AW_T = tdr_pkg::REG_AW;

  // Block check step, LSB first for both CRCs
  function automatic logic [15:0] bccStep(input logic [15:0] acc, input logic [7:0] d,
                                          input logic [1:0] sel);
    logic [15:0] c;
    c = acc ^ {8'h00, d};
    if (sel == tdr_pkg::POLY_LRC)
      c = {8'h00, c[7:0]};
    else
    begin
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ ((sel == tdr_pkg::POLY_CRC16) ? tdr_pkg::CRC16_REFL
                                                            : tdr_pkg::CCITT_REFL)) : (c >> 1);
    end
    return c;
  endfunction : bccStep

  // Receiver state per line
  logic [7:0] shf_ff [NUM_LINES];
  logic [3:0] bitCnt_ff [NUM_LINES];
  logic [NUM_LINES-1:0] synced_ff;
  logic [NUM_LINES-1:0] parBit_ff;
  logic [NUM_LINES-1:0] holdV_ff;
  tdr_pkg::tdr_entry_t holdE_ff [NUM_LINES];
  // FIFO
  tdr_pkg::tdr_entry_t fifoMem_ff [FIFO_DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [PW:0] fifoCnt_ff;
  // Line RAM
  logic [ADDR_W-1:0] curAddr_ff [NUM_LINES];
  logic [15:0] byteCnt_ff [NUM_LINES];
  logic [15:0] proto_ff [NUM_LINES];
  logic [15:0] lstate_ff [NUM_LINES];
  logic [15:0] bccAcc_ff [NUM_LINES];
  logic [1:0] skip_ff [NUM_LINES];
  logic [NUM_LINES-1:0] cntB15_ff;
  // Sequencer and host-visible registers
  tdr_pkg::tdr_seq_t seq_ff;
  tdr_pkg::tdr_entry_t cur_ff;
  tdr_pkg::tdr_cb_t cb_ff;
  tdr_pkg::tdr_cb_t cbsr_ff;
  logic [15:0] ricr_ff;
  logic rxFlag_ff;
  logic irqEn_ff;
  logic [ADDR_W-1:0] tblBase_ff;
  logic [LW-1:0] lsel_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic mCyc_ff;
  logic mWe_ff;
  logic [ADDR_W-1:0] mAdr_ff;
  logic [7:0] mDat_ff;

  logic arbHit;
  logic [LW-1:0] arbIdx;
  logic fifoFull;
  logic fifoEmpty;
  logic pop;
  logic hostAcc;
  logic hostWr;
  logic [REG_AW_T-1:0] regAdr;
  logic resumeWr;
  logic [LW-1:0] cl;
  logic [7:0] mByte;
  tdr_pkg::tdr_cb_t fetchCb;
  tdr_pkg::tdr_cb_t pseudoCb;
  logic [15:0] nxtCnt;
  logic [31:0] nxt_rdat;

  // Host access steals the cycle from the sequencer
  assign hostAcc = wbs_cyc_i & wbs_stb_i;
  // Writes commit at the edge where the master sees ack, so a held request writes once
  assign hostWr = hostAcc & wbs_we_i & ack_ff;
  assign regAdr = wbs_adr_i[REG_AW_T-1:0];
  assign resumeWr = hostWr & (regAdr == tdr_pkg::REG_SCR) & wbs_sel_i[1]
                    & wbs_dat_i[tdr_pkg::SCR_RESUME];
  assign fifoFull = (fifoCnt_ff == (PW+1)'(FIFO_DEPTH));
  assign fifoEmpty = (fifoCnt_ff == '0);
  assign cl = cur_ff.line[LW-1:0];
  assign mByte = 8'(wbm_dat_i >> {mAdr_ff[1:0], 3'b000});
  assign fetchCb = tdr_pkg::tdr_cb_t'(mByte);
  assign pseudoCb = tdr_pkg::tdr_cb_t'(lstate_ff[cl][15:tdr_pkg::STATE_PSEUDO_LO]);
  // Bit 15 is the mode-change flag, so only the low bits count and wrap
  assign nxtCnt = {byteCnt_ff[cl][tdr_pkg::COUNT_MODE_BIT],
                   byteCnt_ff[cl][tdr_pkg::COUNT_MODE_BIT-1:0] + 15'h0001};
  // Draining halts while an interrupt character is outstanding
  assign pop = (seq_ff == tdr_pkg::SEQ_IDLE) & ~hostAcc & ~fifoEmpty & ~rxFlag_ff;

  // Bus outputs
  assign wbs_ack_o = ack_ff;
  assign wbs_dat_o = rdat_ff;
  assign wbm_cyc_o = mCyc_ff;
  assign wbm_stb_o = mCyc_ff;
  assign wbm_we_o = mWe_ff;
  assign wbm_adr_o = {mAdr_ff[ADDR_W-1:2], 2'b00};
  assign wbm_sel_o = 4'(4'h1 << mAdr_ff[1:0]);
  assign wbm_dat_o = {4{mDat_ff}};
  assign rxIrq = rxFlag_ff & irqEn_ff;

  // Fixed-priority pick of one waiting line per cycle, lowest number first
  always_comb
  begin
    arbHit = 1'b0;
    arbIdx = '0;
    for (int i = NUM_LINES - 1; i >= 0; i--)
    begin
      if (holdV_ff[i])
      begin
        arbHit = 1'b1;
        arbIdx = LW'(i);
      end
    end
  end

  // Line receivers with a one-character holding register each
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      synced_ff <= '0;
      parBit_ff <= '0;
      holdV_ff <= '0;
      for (int i = 0; i < NUM_LINES; i++)
      begin
        shf_ff[i] <= '0;
        bitCnt_ff[i] <= '0;
        holdE_ff[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_LINES; i++)
      begin
        if (arbHit && arbIdx == LW'(i))
          holdV_ff[i] <= 1'b0;
        if (rxBitStb[i] && i < SYNC_LINES)
        begin
          shf_ff[i] <= {rxData[i], shf_ff[i][7:1]};
          if (!synced_ff[i])
          begin
            if ({rxData[i], shf_ff[i][7:1]} == SYNC_CHAR)
            begin
              synced_ff[i] <= 1'b1;
              bitCnt_ff[i] <= '0;
            end
          end
          else if (bitCnt_ff[i] == tdr_pkg::SBIT_LAST)
          begin
            // Overrun when the previous character was never taken
            holdE_ff[i] <= '{err: {1'b0, holdV_ff[i] & ~(arbHit && arbIdx == LW'(i)), 1'b0},
                             line: 4'(i), ch: {rxData[i], shf_ff[i][7:1]}};
            holdV_ff[i] <= 1'b1;
            bitCnt_ff[i] <= '0;
          end
          else
            bitCnt_ff[i] <= bitCnt_ff[i] + 4'h1;
        end
        else if (rxBitStb[i])
        begin
          if (bitCnt_ff[i] == '0)
          begin
            if (!rxData[i])
              bitCnt_ff[i] <= 4'h1;
          end
          else if (bitCnt_ff[i] <= tdr_pkg::ABIT_LAST_DATA)
          begin
            shf_ff[i] <= {rxData[i], shf_ff[i][7:1]};
            bitCnt_ff[i] <= (bitCnt_ff[i] == tdr_pkg::ABIT_LAST_DATA && !PAR_EN)
                            ? tdr_pkg::ABIT_PARITY + 4'h1 : bitCnt_ff[i] + 4'h1;
          end
          else if (bitCnt_ff[i] == tdr_pkg::ABIT_PARITY)
          begin
            parBit_ff[i] <= rxData[i];
            bitCnt_ff[i] <= bitCnt_ff[i] + 4'h1;
          end
          else
          begin
            // Stop bit: even parity and framing checked here
            holdE_ff[i] <= '{err: {~rxData[i], holdV_ff[i] & ~(arbHit && arbIdx == LW'(i)),
                                   PAR_EN & (^{shf_ff[i], parBit_ff[i]})},
                             line: 4'(i), ch: shf_ff[i]};
            holdV_ff[i] <= 1'b1;
            bitCnt_ff[i] <= '0;
          end
        end
      end
    end
  end

  // Shared character FIFO; a push into a full FIFO is discarded
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      fifoCnt_ff <= '0;
    end
    else
    begin
      if (arbHit && !fifoFull)
      begin
        fifoMem_ff[wrPtr_ff] <= holdE_ff[arbIdx];
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop)
        rdPtr_ff <= rdPtr_ff + 1'b1;
      fifoCnt_ff <= fifoCnt_ff + (PW+1)'(arbHit && !fifoFull) - (PW+1)'(pop);
    end
  end

  // Register read mux
  always_comb
  begin
    nxt_rdat = '0;
    case (regAdr)
      tdr_pkg::REG_SCR: nxt_rdat = 32'({rxFlag_ff, irqEn_ff}) << tdr_pkg::SCR_IRQ_EN;
      tdr_pkg::REG_RICR: nxt_rdat = {16'h0000, ricr_ff};
      tdr_pkg::REG_CBSR: nxt_rdat = {24'h000000, cbsr_ff};
      tdr_pkg::REG_TBASE: nxt_rdat = 32'(tblBase_ff);
      tdr_pkg::REG_LSEL: nxt_rdat = 32'(lsel_ff);
      tdr_pkg::REG_LADDR: nxt_rdat = 32'(curAddr_ff[lsel_ff]);
      tdr_pkg::REG_LCOUNT: nxt_rdat = {16'h0000, byteCnt_ff[lsel_ff]};
      tdr_pkg::REG_LPROTO: nxt_rdat = {16'h0000, proto_ff[lsel_ff]};
      tdr_pkg::REG_LSTATE: nxt_rdat = {16'h0000, lstate_ff[lsel_ff]};
      tdr_pkg::REG_LBCC: nxt_rdat = {16'h0000, bccAcc_ff[lsel_ff]};
      default: nxt_rdat = '0;
    endcase
  end

  // Register bus slave: one wait state, every address acknowledged
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      irqEn_ff <= 1'b0;
      tblBase_ff <= '0;
      lsel_ff <= '0;
    end
    else
    begin
      ack_ff <= hostAcc & ~ack_ff;
      rdat_ff <= (hostAcc & ~ack_ff) ? nxt_rdat : '0;
      if (hostWr && regAdr == tdr_pkg::REG_SCR && wbs_sel_i[0])
        irqEn_ff <= wbs_dat_i[tdr_pkg::SCR_IRQ_EN];
      if (hostWr && regAdr == tdr_pkg::REG_TBASE)
        tblBase_ff <= ADDR_W'(wbs_dat_i);
      if (hostWr && regAdr == tdr_pkg::REG_LSEL)
        lsel_ff <= wbs_dat_i[LW-1:0];
    end
  end

  // Sequencer, interrupt character, and per-line RAM
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      seq_ff <= tdr_pkg::SEQ_IDLE;
      cur_ff <= '0;
      cb_ff <= '0;
      cbsr_ff <= '0;
      ricr_ff <= '0;
      rxFlag_ff <= 1'b0;
      mCyc_ff <= 1'b0;
      mWe_ff <= 1'b0;
      mAdr_ff <= '0;
      mDat_ff <= '0;
      cntB15_ff <= '0;
      for (int i = 0; i < NUM_LINES; i++)
      begin
        curAddr_ff[i] <= '0;
        byteCnt_ff[i] <= '0;
        proto_ff[i] <= '0;
        lstate_ff[i] <= '0;
        bccAcc_ff[i] <= '0;
        skip_ff[i] <= '0;
      end
    end
    else
    begin
      // Clear first so a raise in the same cycle wins
      if (resumeWr)
        rxFlag_ff <= 1'b0;
      case (seq_ff)
        tdr_pkg::SEQ_IDLE:
          if (pop)
          begin
            cur_ff <= fifoMem_ff[rdPtr_ff];
            if (fifoMem_ff[rdPtr_ff].err != '0)
            begin
              ricr_ff <= {1'b0, fifoMem_ff[rdPtr_ff]};
              cbsr_ff <= '{rsvd: 2'b00, store: 1'b0, bcc: 1'b0, irq: 1'b0,
                           mode: lstate_ff[fifoMem_ff[rdPtr_ff].line[LW-1:0]][2:0]};
              rxFlag_ff <= 1'b1;
              seq_ff <= tdr_pkg::SEQ_WAIT;
            end
            else if (proto_ff[fifoMem_ff[rdPtr_ff].line[LW-1:0]][tdr_pkg::PROTO_COUNT_RX])
            begin
              // Count protocol: no lookup, check everything, hold back the check bytes
              cb_ff <= '{rsvd: 2'b00, store: skip_ff[fifoMem_ff[rdPtr_ff].line[LW-1:0]] == '0,
                         bcc: 1'b1, irq: 1'b0, mode: 3'h0};
              seq_ff <= tdr_pkg::SEQ_ACT;
            end
            else
            begin
              mCyc_ff <= 1'b1;
              mWe_ff <= 1'b0;
              mAdr_ff <= tblBase_ff + ADDR_W'({lstate_ff[fifoMem_ff[rdPtr_ff].line[LW-1:0]][2:0],
                                               fifoMem_ff[rdPtr_ff].ch});
              seq_ff <= tdr_pkg::SEQ_FETCH;
            end
          end
        tdr_pkg::SEQ_FETCH:
          if (wbm_ack_i)
          begin
            mCyc_ff <= 1'b0;
            if (fetchCb.irq)
            begin
              ricr_ff <= {tdr_pkg::CODE_SPECIAL, cur_ff.line, cur_ff.ch};
              cbsr_ff <= fetchCb;
              rxFlag_ff <= 1'b1;
              seq_ff <= tdr_pkg::SEQ_WAIT;
            end
            else
            begin
              cb_ff <= fetchCb;
              seq_ff <= tdr_pkg::SEQ_ACT;
            end
          end
        tdr_pkg::SEQ_WAIT:
          if (!rxFlag_ff && !hostAcc)
          begin
            cb_ff <= cbsr_ff;
            seq_ff <= tdr_pkg::SEQ_ACT;
          end
        tdr_pkg::SEQ_ACT:
          if (!hostAcc)
          begin
            lstate_ff[cl][2:0] <= cb_ff.mode;
            if (cb_ff.bcc)
              bccAcc_ff[cl] <= bccStep(bccAcc_ff[cl], cur_ff.ch,
                                       proto_ff[cl][tdr_pkg::PROTO_POLY_LO +: 2]);
            if (proto_ff[cl][tdr_pkg::PROTO_COUNT_RX] && skip_ff[cl] != '0)
              skip_ff[cl] <= skip_ff[cl] - 2'h1;
            if (cb_ff.store)
            begin
              mCyc_ff <= 1'b1;
              mWe_ff <= 1'b1;
              mAdr_ff <= curAddr_ff[cl];
              mDat_ff <= cur_ff.ch;
              seq_ff <= tdr_pkg::SEQ_STORE;
            end
            else
              seq_ff <= tdr_pkg::SEQ_IDLE;
          end
        tdr_pkg::SEQ_STORE:
          if (wbm_ack_i)
          begin
            mCyc_ff <= 1'b0;
            mWe_ff <= 1'b0;
            curAddr_ff[cl] <= curAddr_ff[cl] + ADDR_W'(1);
            byteCnt_ff[cl] <= nxtCnt;
            if (nxtCnt[tdr_pkg::COUNT_MODE_BIT-1:0] == '0)
            begin
              if (!cntB15_ff[cl])
                lstate_ff[cl][2:0] <= pseudoCb.mode;
              if (proto_ff[cl][tdr_pkg::PROTO_COUNT_RX])
                skip_ff[cl] <= tdr_pkg::BCC_CHARS;
              ricr_ff <= {tdr_pkg::CODE_EXHAUST, cur_ff.line, cur_ff.ch};
              rxFlag_ff <= 1'b1;
            end
            seq_ff <= tdr_pkg::SEQ_IDLE;
          end
        default:
          seq_ff <= tdr_pkg::SEQ_IDLE;
      endcase
      // Host writes land last so they win over a concurrent update
      if (hostWr && regAdr == tdr_pkg::REG_CBSR && wbs_sel_i[0])
        cbsr_ff <= tdr_pkg::tdr_cb_t'(wbs_dat_i[7:0]);
      if (hostWr && regAdr == tdr_pkg::REG_LADDR)
        curAddr_ff[lsel_ff] <= ADDR_W'(wbs_dat_i);
      if (hostWr && regAdr == tdr_pkg::REG_LCOUNT)
      begin
        byteCnt_ff[lsel_ff] <= wbs_dat_i[15:0];
        cntB15_ff[lsel_ff] <= wbs_dat_i[tdr_pkg::COUNT_MODE_BIT];
      end
      if (hostWr && regAdr == tdr_pkg::REG_LPROTO)
        proto_ff[lsel_ff] <= wbs_dat_i[15:0];
      if (hostWr && regAdr == tdr_pkg::REG_LSTATE)
        lstate_ff[lsel_ff] <= wbs_dat_i[15:0];
      if (hostWr && regAdr == tdr_pkg::REG_LBCC)
      begin
        bccAcc_ff[lsel_ff] <= wbs_dat_i[15:0];
        skip_ff[lsel_ff] <= '0;
      end
    end
  end
endmodule : tdr_rx_engine

// *** tdr_rx_engine_properties.sv ***
// Port-level checks of the receive engine's buses and interrupt
`timescale 1ns/1ps
module tdr_rx_engine_properties #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic wbs_cyc_i,
  input wire logic wbs_stb_i,
  input wire logic wbs_we_i,
  input wire logic [31:0] wbs_adr_i,
  input wire logic [3:0] wbs_sel_i,
  input wire logic [31:0] wbs_dat_i,
  input wire logic wbs_ack_o,
  // Memory master and interrupt
  input wire logic wbm_cyc_o,
  input wire logic wbm_we_o,
  input wire logic [ADDR_W-1:0] wbm_adr_o,
  input wire logic [31:0] wbm_dat_o,
  input wire logic wbm_ack_i,
  input wire logic rxIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Write to the system control register at the edge where it takes effect
  logic scrWr;
  assign scrWr = wbs_cyc_i & wbs_stb_i & wbs_ack_o & wbs_we_i
    & (wbs_adr_i[7:0] == tdr_pkg::REG_SCR);

  property p_ack_one;
    wbs_ack_o |=> !wbs_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("register ack longer than one cycle");
  property p_ack_due;
    wbs_cyc_i && wbs_stb_i && !wbs_ack_o |=> wbs_ack_o;
  endproperty
  a_ack_due: assert property (p_ack_due)
    else $error("register request not answered next cycle");
  property p_ack_cause;
    wbs_ack_o |-> $past(wbs_cyc_i && wbs_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("register ack without request");
  property p_resume;
    scrWr && wbs_sel_i[1] && wbs_dat_i[tdr_pkg::SCR_RESUME] |=> !rxIrq;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not clear the interrupt");
  property p_mask;
    scrWr && wbs_sel_i[0] && !wbs_dat_i[tdr_pkg::SCR_IRQ_EN] |=> !rxIrq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt raised while disabled");
  property p_mst_hold;
    wbm_cyc_o && !wbm_ack_i |=> wbm_cyc_o && $stable(wbm_adr_o)
      && $stable(wbm_dat_o) && $stable(wbm_we_o);
  endproperty
  a_mst_hold: assert property (p_mst_hold)
    else $error("master request changed before ack");
  property p_mst_drop;
    wbm_cyc_o && wbm_ack_i |=> !wbm_cyc_o;
  endproperty
  a_mst_drop: assert property (p_mst_drop)
    else $error("master cycle not released after ack");
  property p_stall;
    rxIrq && $past(rxIrq) |-> !$rose(wbm_cyc_o);
  endproperty
  a_stall: assert property (p_stall)
    else $error("master transfer started while awaiting host");
endmodule : tdr_rx_engine_properties

bind tdr_rx_engine tdr_rx_engine_properties #(.ADDR_W(ADDR_W)) tdr_rx_engine_properties_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .wbs_cyc_i(wbs_cyc_i), .wbs_stb_i(wbs_stb_i),
  .wbs_we_i(wbs_we_i), .wbs_adr_i(wbs_adr_i), .wbs_sel_i(wbs_sel_i), .wbs_dat_i(wbs_dat_i),
  .wbs_ack_o(wbs_ack_o), .wbm_cyc_o(wbm_cyc_o), .wbm_we_o(wbm_we_o), .wbm_adr_o(wbm_adr_o),
  .wbm_dat_o(wbm_dat_o), .wbm_ack_i(wbm_ack_i), .rxIrq(rxIrq));

// *** tdr_mem_model.sv ***
// Host memory model answering the engine's bus-master byte cycles
`timescale 1ns/1ps
module tdr_mem_model (
  // Clock
  input wire logic clk_sys,
  // Bus from the engine
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [31:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] datW,
  output logic [31:0] datR = 32'h0,
  output logic ack = 1'b0,
  // Answer delay in cycles
  input wire logic [3:0] lat
);
  logic [7:0] mem [0:4095];
  logic [3:0] waitCnt_ff = 4'h0;
  logic [11:0] idx;
  // Byte index from the word address and the one-hot lane
  always_comb
  begin
    idx = {adr[11:2], 2'h0};
    for (int k = 0; k < 4; k++)
    begin
      if (sel[k])
      begin
        idx[1:0] = k[1:0];
      end
    end
  end
  // Data lines toggle when idle so a stale sample never passes for an answer
  // Plain always: the bench preloads the memory array from outside
  always @(posedge clk_sys)
  begin
    if (cyc && stb && !ack && waitCnt_ff >= lat)
    begin
      ack <= 1'b1;
      waitCnt_ff <= 4'h0;
      datR <= {4{mem[idx]}};
      if (we)
      begin
        mem[idx] <= datW[8*idx[1:0] +: 8];
      end
    end
    else
    begin
      ack <= 1'b0;
      datR <= ~datR;
      if (cyc && stb && !ack)
      begin
        waitCnt_ff <= waitCnt_ff + 4'h1;
      end
    end
  end
endmodule : tdr_mem_model

// *** testbench.sv ***
// Self-checking bench for the table-driven receive engine
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wbsCyc = 1'b0;
  logic wbsStb = 1'b0;
  logic wbsWe = 1'b0;
  logic [31:0] wbsAdr = 32'h0;
  logic [3:0] wbsSel = 4'h0;
  logic [31:0] wbsDat = 32'h0;
  logic [31:0] wbsDatO;
  logic wbsAck;
  logic wbmCyc, wbmStb, wbmWe, wbmAck, rxIrq;
  logic [31:0] wbmAdr, wbmDatO, wbmDatI, rdData;
  logic [3:0] wbmSel;
  logic [3:0] lat = 4'h0;
  logic [15:0] rxData = 16'hFFFF;
  logic [15:0] rxBitStb = 16'h0;
  int n_errors = 0;
  int n_tests = 0;
  // Register rows: address, write data, expected read back
  logic [7:0] rowAdr [5] = '{8'h08, 8'h04, 8'h40, 8'h00, 8'h08};
  logic [31:0] rowDat [5] = '{32'hFFA5, 32'hFFFF, 32'h1234, 32'h80, 32'h0};
  logic [31:0] rowExp [5] = '{32'hA5, 32'h0, 32'h0, 32'h0, 32'h0};

  always #5 clk_sys = ~clk_sys;

  tdr_rx_engine tdr_rx_engine_i (.clk_sys(clk_sys), .rst_n(rst_n), .wbs_cyc_i(wbsCyc),
    .wbs_stb_i(wbsStb), .wbs_we_i(wbsWe), .wbs_adr_i(wbsAdr), .wbs_sel_i(wbsSel),
    .wbs_dat_i(wbsDat), .wbs_dat_o(wbsDatO), .wbs_ack_o(wbsAck), .wbm_cyc_o(wbmCyc),
    .wbm_stb_o(wbmStb), .wbm_we_o(wbmWe), .wbm_adr_o(wbmAdr), .wbm_sel_o(wbmSel),
    .wbm_dat_o(wbmDatO), .wbm_dat_i(wbmDatI), .wbm_ack_i(wbmAck), .rxData(rxData),
    .rxBitStb(rxBitStb), .rxIrq(rxIrq));
  tdr_mem_model tdr_mem_model_i (.clk_sys(clk_sys), .cyc(wbmCyc), .stb(wbmStb), .we(wbmWe),
    .adr(wbmAdr), .sel(wbmSel), .datW(wbmDatO), .datR(wbmDatI), .ack(wbmAck), .lat(lat));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One classic cycle; read data is taken at the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    wbsCyc <= 1'b1;
    wbsStb <= 1'b1;
    wbsWe <= we;
    wbsAdr <= {24'h0, a};
    wbsSel <= 4'hF;
    wbsDat <= d;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (wbsAck !== 1'b1 && k < 50);
    rdData = wbsDatO;
    wbsCyc <= 1'b0;
    wbsStb <= 1'b0;
    if (k >= 50) chk(32'h0, 32'h1);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask : rd
  task automatic chkIrq(input logic e);
    @(posedge clk_sys);
    chk({31'h0, rxIrq}, {31'h0, e});
  endtask : chkIrq
  task automatic sbit(input int ln, input logic b);
    @(posedge clk_sys);
    rxData[ln] <= b;
    rxBitStb[ln] <= 1'b1;
    @(posedge clk_sys);
    rxBitStb[ln] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : sbit
  task automatic sbyte(input int ln, input logic [7:0] c);
    for (int i = 0; i < 8; i++) sbit(ln, c[i]);
  endtask : sbyte
  task automatic waitIrq;
    int k;
    k = 0;
    while (rxIrq !== 1'b1 && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk({31'h0, rxIrq}, 32'h1);
  endtask : waitIrq
  task automatic waitMem(input int i, input logic [7:0] v);
    int k;
    k = 0;
    while (tdr_mem_model_i.mem[i] !== v && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk({24'h0, tdr_mem_model_i.mem[i]}, {24'h0, v});
  endtask : waitMem
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Watchdog against a hung handshake
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    for (int i = 0; i < 4096; i++) tdr_mem_model_i.mem[i] = 8'hEE;
    tdr_mem_model_i.mem[12'h041] = 8'h31; // Store, check, go to mode 1
    tdr_mem_model_i.mem[12'h141] = 8'h31; // Store, check, stay in mode 1
    tdr_mem_model_i.mem[12'h142] = 8'h08; // Interrupt only
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    chkIrq(1'b0);
    rd(tdr_pkg::REG_SCR, 32'h0);
    rd(tdr_pkg::REG_LCOUNT, 32'h0);
    for (int r = 0; r < 5; r++)
    begin
      wb(1'b1, rowAdr[r], rowDat[r]);
      rd(rowAdr[r], rowExp[r]);
    end
    $display("register test done");
    wb(1'b1, tdr_pkg::REG_TBASE, 32'h0);
    wb(1'b1, tdr_pkg::REG_LSEL, 32'h0);
    wb(1'b1, tdr_pkg::REG_LADDR, 32'h800);
    wb(1'b1, tdr_pkg::REG_LCOUNT, 32'hFFFE);
    wb(1'b1, tdr_pkg::REG_LPROTO, 32'h0);
    wb(1'b1, tdr_pkg::REG_LSTATE, 32'h0);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h40);
    // Noise before the sync pattern must not reach memory
    sbyte(0, 8'h41);
    sbyte(0, 8'h96);
    sbyte(0, 8'h41);
    sbyte(0, 8'h41);
    waitIrq();
    rd(tdr_pkg::REG_RICR, 32'h9041);
    chk({24'h0, tdr_mem_model_i.mem[12'h800]}, 32'h41);
    chk({24'h0, tdr_mem_model_i.mem[12'h801]}, 32'h41);
    rd(tdr_pkg::REG_LADDR, 32'h802);
    rd(tdr_pkg::REG_LSTATE, 32'h1);
    wb(1'b1, tdr_pkg::REG_CBSR, 32'h1);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h140);
    chkIrq(1'b0);
    $display("store test done");
    wb(1'b1, tdr_pkg::REG_LADDR, 32'h810);
    wb(1'b1, tdr_pkg::REG_LCOUNT, 32'hFFF0);
    sbyte(0, 8'h42);
    waitIrq();
    rd(tdr_pkg::REG_RICR, 32'h8042);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h0);
    chkIrq(1'b0);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h40);
    chkIrq(1'b1);
    wb(1'b1, tdr_pkg::REG_CBSR, 32'h31);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h140);
    waitMem(12'h810, 8'h42);
    rd(tdr_pkg::REG_LBCC, 32'h42);
    $display("special test done");
    // Async frame with a low stop bit, slow memory from here on
    lat <= 4'h3;
    sbit(8, 1'b0);
    sbyte(8, 8'h55);
    sbit(8, 1'b0);
    sbit(8, 1'b0);
    rxData[8] <= 1'b1;
    waitIrq();
    rd(tdr_pkg::REG_RICR, 32'h4855);
    sbyte(0, 8'h41);
    repeat (100) @(posedge clk_sys);
    chk({24'h0, tdr_mem_model_i.mem[12'h811]}, 32'hEE);
    wb(1'b1, tdr_pkg::REG_CBSR, 32'h1);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h140);
    waitMem(12'h811, 8'h41);
    $display("error test done");
    // Count protocol: last buffer byte switches mode, the two check bytes stay out of memory
    wb(1'b1, tdr_pkg::REG_LPROTO, 32'h20);
    wb(1'b1, tdr_pkg::REG_LSTATE, 32'h500);
    wb(1'b1, tdr_pkg::REG_LADDR, 32'h900);
    wb(1'b1, tdr_pkg::REG_LCOUNT, 32'h7FFF);
    wb(1'b1, tdr_pkg::REG_LBCC, 32'h0);
    sbyte(0, 8'h11);
    sbyte(0, 8'h22);
    sbyte(0, 8'h44);
    waitIrq();
    rd(tdr_pkg::REG_RICR, 32'h9011);
    rd(tdr_pkg::REG_LSTATE, 32'h505);
    wb(1'b1, tdr_pkg::REG_SCR, 32'h140);
    repeat (50) @(posedge clk_sys);
    rd(tdr_pkg::REG_LBCC, 32'h77);
    chk({24'h0, tdr_mem_model_i.mem[12'h900]}, 32'h11);
    chk({24'h0, tdr_mem_model_i.mem[12'h901]}, 32'hEE);
    $display("count test done");
    wrap_up();
  end
endmodule : testbench
